// file: ciq_pkg.sv
// package for the camera identity query responder
// assumes one clock domain; frames arrive already delimited and checked
package ciq_pkg;
  // ======================================
  // command identifiers
  localparam logic [7:0] CMD_VENDOR = 8'h01;
  localparam logic [7:0] CMD_MODEL = 8'h02;
  localparam logic [7:0] CMD_PRODUCT = 8'h03;
  localparam logic [7:0] CMD_SERIAL = 8'h04;
  localparam logic [7:0] CMD_CAM_VER = 8'h05;
  localparam logic [7:0] CMD_MCU_VER = 8'h40;
  localparam logic [7:0] CMD_PL_VER = 8'h41;
  // ======================================
  // frame fields
  localparam logic FLAG_READ = 1'b1;
  localparam logic FLAG_REPLY = 1'b0;
  localparam logic [7:0] LEN_VERSION = 8'h03;
  localparam logic [7:0] LEN_STRING = 8'h10;
  localparam logic [7:0] PL_BYTE3 = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int STR_BYTES = 16;
  localparam int HDR_BYTES = 3;
endpackage

// file: ciq_payload_rom.sv
// payload byte lookup for the identity query responder
// assumes strings are presented zero padded to sixteen bytes
module ciq_payload_rom #(
  parameter logic [127:0] VENDOR_STR = 128'h0,
  parameter logic [127:0] MODEL_STR = 128'h0,
  parameter logic [127:0] PRODUCT_STR = 128'h0,
  parameter logic [127:0] SERIAL_STR = 128'h0,
  parameter logic [15:0] MCU_VER = 16'h0100,
  parameter logic [15:0] PL_VER = 16'h0100,
  parameter logic [15:0] CAM_VER = 16'h0100,
  parameter logic [7:0] PROTO_VER = 8'h01
) (
  input wire logic [7:0] cmd,
  input wire logic [3:0] idx,
  output logic [7:0] data
);
  logic [127:0] str;
  // ======================================
  // string select; byte 0 sits in bits 127:120
  always_comb begin
    case (cmd)
      ciq_pkg::CMD_VENDOR: str = VENDOR_STR;
      ciq_pkg::CMD_MODEL: str = MODEL_STR;
      ciq_pkg::CMD_PRODUCT: str = PRODUCT_STR;
      default: str = SERIAL_STR;
    endcase
  end
  // ======================================
  // byte select
  always_comb begin
    data = ciq_pkg::ZERO_BYTE;
    case (cmd)
      ciq_pkg::CMD_MCU_VER: begin
        case (idx)
          4'h0: data = MCU_VER[7:0];
          4'h1: data = MCU_VER[15:8];
          default: data = PROTO_VER;
        endcase
      end
      ciq_pkg::CMD_PL_VER: begin
        case (idx)
          4'h0: data = PL_VER[7:0];
          4'h1: data = PL_VER[15:8];
          default: data = ciq_pkg::PL_BYTE3;
        endcase
      end
      ciq_pkg::CMD_CAM_VER: begin
        case (idx)
          4'h0: data = CAM_VER[7:0];
          4'h1: data = CAM_VER[15:8];
          default: data = PROTO_VER;
        endcase
      end
      // zero padding doubles as terminator; a full string has none
      default: data = str[8'(127 - 8 * idx) -: 8];
    endcase
  end
endmodule

// file: ciq_responder.sv
// camera identity query responder: parses read frames, sends replies
// assumes a byte stream with valid/ready; framing and checksum done outside
module ciq_responder #(
  parameter logic [127:0] VENDOR_STR = 128'h0,
  parameter logic [127:0] MODEL_STR = 128'h0,
  parameter logic [127:0] PRODUCT_STR = 128'h0,
  parameter logic [127:0] SERIAL_STR = 128'h0,
  parameter logic [15:0] MCU_VER = 16'h0100,
  parameter logic [15:0] PL_VER = 16'h0100,
  parameter logic [15:0] CAM_VER = 16'h0100,
  parameter logic [7:0] PROTO_VER = 8'h01
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  output logic bad_frame
);
  typedef enum logic [5:0] {
    ST_ID = 6'h01,
    ST_FLAG = 6'h02,
    ST_LEN = 6'h04,
    ST_HDR = 6'h08,
    ST_DATA = 6'h10,
    ST_DROP = 6'h20
  } ciq_state_t;

  ciq_state_t state_reg, state_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] len_reg, len_next;
  logic [3:0] idx_reg, idx_next;
  logic [1:0] hdr_reg, hdr_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic tx_last_reg, tx_last_next;
  logic rx_ready_reg, rx_ready_next;
  logic bad_reg, bad_next;
  logic [7:0] rom_byte;
  logic [7:0] cur_idx;
  logic known_len;
  logic take;
  logic send;

  ciq_payload_rom #(
    .VENDOR_STR(VENDOR_STR),
    .MODEL_STR(MODEL_STR),
    .PRODUCT_STR(PRODUCT_STR),
    .SERIAL_STR(SERIAL_STR),
    .MCU_VER(MCU_VER),
    .PL_VER(PL_VER),
    .CAM_VER(CAM_VER),
    .PROTO_VER(PROTO_VER)
  ) u_rom (
    .cmd(cmd_reg),
    // the registered index: the byte loaded now is the one it points at
    .idx(idx_reg),
    .data(rom_byte)
  );

  // ======================================
  // expected length per command; unknown ids or lengths are not answered
  always_comb begin
    case (cmd_reg)
      ciq_pkg::CMD_VENDOR, ciq_pkg::CMD_MODEL, ciq_pkg::CMD_PRODUCT,
      ciq_pkg::CMD_SERIAL: known_len = (rx_data == ciq_pkg::LEN_STRING);
      ciq_pkg::CMD_CAM_VER, ciq_pkg::CMD_MCU_VER,
      ciq_pkg::CMD_PL_VER: known_len = (rx_data == ciq_pkg::LEN_VERSION);
      default: known_len = 1'b0;
    endcase
  end

  assign take = rx_valid & rx_ready_reg;
  // a byte leaves when the held output is empty or being accepted
  assign send = ~tx_valid_reg | tx_ready;
  assign cur_idx = {4'h0, idx_reg};

  // ======================================
  // frame parse and reply sequencer
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    hdr_next = hdr_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg & ~tx_ready;
    tx_last_next = tx_last_reg & ~tx_ready;
    rx_ready_next = rx_ready_reg;
    bad_next = 1'b0;
    case (state_reg)
      ST_ID: begin
        if (take) begin
          cmd_next = rx_data;
          state_next = ST_FLAG;
        end
      end
      ST_FLAG: begin
        if (take) begin
          // a write frame has data bytes we cannot size here; drop it
          if (rx_data[0] == ciq_pkg::FLAG_READ) begin
            state_next = ST_LEN;
          end else begin
            bad_next = 1'b1;
            state_next = ST_ID;
          end
        end
      end
      ST_LEN: begin
        if (take) begin
          if (known_len) begin
            // whole read frame is in: only now start replying
            len_next = rx_data;
            hdr_next = 2'd0;
            idx_next = 4'h0;
            rx_ready_next = 1'b0;
            state_next = ST_HDR;
          end else begin
            bad_next = 1'b1;
            state_next = ST_ID;
          end
        end
      end
      ST_HDR: begin
        if (send) begin
          tx_valid_next = 1'b1;
          tx_last_next = 1'b0;
          case (hdr_reg)
            2'd0: tx_data_next = cmd_reg;
            2'd1: tx_data_next = {7'h00, ciq_pkg::FLAG_REPLY};
            default: tx_data_next = len_reg;
          endcase
          hdr_next = hdr_reg + 2'd1;
          if (hdr_reg == 2'(ciq_pkg::HDR_BYTES - 1)) begin
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (send) begin
          tx_valid_next = 1'b1;
          tx_data_next = rom_byte;
          tx_last_next = (cur_idx == len_reg - 8'h01);
          idx_next = idx_reg + 4'h1; // ascending order
          if (cur_idx == len_reg - 8'h01) begin
            rx_ready_next = 1'b1;
            state_next = ST_ID;
          end
        end
      end
      default: begin
        rx_ready_next = 1'b1;
        state_next = ST_ID;
      end
    endcase
  end

  // ======================================
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_ID;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      idx_reg <= 4'h0;
      hdr_reg <= 2'd0;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_last_reg <= 1'b0;
      rx_ready_reg <= 1'b1;
      bad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      hdr_reg <= hdr_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      tx_last_reg <= tx_last_next;
      rx_ready_reg <= rx_ready_next;
      bad_reg <= bad_next;
    end
  end

  assign rx_ready = rx_ready_reg;
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_last = tx_last_reg;
  assign bad_frame = bad_reg;
endmodule

// file: ciq_responder_monitor.sv
// checker for ciq_responder
// bound to the responder; sees its ports only
module ciq_responder_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic bad_frame
);
  logic [1:0] rcnt_reg, rcnt_next;
  logic [4:0] tpos_reg, tpos_next;
  logic [7:0] id_reg, id_next;
  logic take;
  assign take = rx_valid && rx_ready;
  // ==========
  // frame and reply position; a flag of 0 ends the frame early
  always_comb begin
    rcnt_next = rcnt_reg;
    if (take) begin
      rcnt_next = (rcnt_reg == 2'h2 || (rcnt_reg == 2'h1 && !rx_data[0])) ? 2'h0 : rcnt_reg + 2'h1;
    end
    id_next = (take && rcnt_reg == 2'h0) ? rx_data : id_reg;
    tpos_next = (tx_valid && tx_ready) ? (tx_last ? 5'h00 : tpos_reg + 5'h01) : tpos_reg;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_reg <= 2'h0;
      tpos_reg <= 5'h00;
      id_reg <= 8'h00;
    end else begin
      rcnt_reg <= rcnt_next;
      tpos_reg <= tpos_next;
      id_reg <= id_next;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  tx_hold_a:
    assert property (tx_valid && !tx_ready |=> $stable({tx_valid, tx_data, tx_last}))
    else $error("reply byte moved while stalled");
  rx_block_a:
    assert property (tx_valid && !tx_last |-> !rx_ready) else $error("rx open mid reply");
  reply_id_a:
    assert property (tx_valid && tpos_reg == 5'h00 |-> tx_data == id_reg) else $error("bad id");
  reply_flag_a:
    assert property (tx_valid && tpos_reg == 5'h01 |-> tx_data == 8'h00) else $error("bad flag");
  reply_len_a:
    assert property (tx_valid && tpos_reg == 5'h02 |-> tx_data inside {8'h03, 8'h10})
    else $error("bad length");
  flag_drop_a:
    assert property (take && rcnt_reg == 2'h1 && !rx_data[0] |=> bad_frame ##1 !bad_frame)
    else $error("write flag not dropped");
  reply_start_a:
    assert property (take && rcnt_reg == 2'h2 |=> bad_frame or (!rx_ready ##[1:2] tx_valid))
    else $error("reply late");
  bad_src_a:
    assert property (bad_frame |-> $past(take && rcnt_reg != 2'h0)) else $error("stray drop");
endmodule
bind ciq_responder ciq_responder_monitor mon (.mclk, .rst_n, .rx_data, .rx_valid, .rx_ready,
  .tx_data, .tx_valid, .tx_last, .tx_ready, .bad_frame);

// file: ciq_host.sv
// host model: offers query bytes and collects reply bytes
// assumes its tasks are called at the falling edge of mclk
module ciq_host (
  input wire logic mclk,
  input wire logic slow,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got[$];
  initial {rx_data, rx_valid, tx_ready} = {8'h00, 1'b0, 1'b1};
  // slow host halves the reply rate to force stalls
  always @(negedge mclk) tx_ready <= slow ? !tx_ready : 1'b1;
  always @(posedge mclk) if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  task automatic put(input logic [7:0] b);
    rx_data = b;
    rx_valid = 1'b1;
    while (!rx_ready) @(negedge mclk);
    @(negedge mclk);
  endtask
  // released line shows the inverse so stale data cannot pass
  task automatic idle();
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

// file: camera_identity_query_responder_tb.sv
// testbench for the identity query responder
// assumes the host model and bound checker are compiled first
module camera_identity_query_responder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] id; logic [7:0] len; logic [127:0] pay;} ciq_row_t;
  localparam logic [127:0] VSTR = {16{8'h5a}};
  localparam logic [127:0] MSTR = {8'h4d, 8'h31, 112'h0};
  localparam logic [127:0] SSTR = {{15{8'h39}}, 8'h00};
  // product string, camera version and protocol version stay at the responder defaults
  ciq_row_t rows[7] = '{'{8'h40, 8'h03, {24'h341201, 104'h0}},
    '{8'h41, 8'h03, {24'h670500, 104'h0}}, '{8'h05, 8'h03, {24'h000101, 104'h0}},
    '{8'h01, 8'h10, VSTR}, '{8'h02, 8'h10, MSTR}, '{8'h03, 8'h10, 128'h0},
    '{8'h04, 8'h10, SSTR}};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_last, tx_ready, bad_frame;
  int n_tests = 0;
  int n_mismatch = 0;
  int n_bad = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  ciq_responder #(.VENDOR_STR(VSTR), .MODEL_STR(MSTR), .SERIAL_STR(SSTR), .MCU_VER(16'h1234),
    .PL_VER(16'h0567)) uut (
    .mclk, .rst_n, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .bad_frame);
  ciq_host h (.mclk, .slow, .rx_ready, .tx_data, .tx_valid, .tx_last, .rx_data, .rx_valid,
    .tx_ready);
  // ==========
  // shared tasks
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (bad_frame === 1'b1) n_bad++;
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic frame(input logic [7:0] id, input logic [7:0] fl, input logic [7:0] len);
    h.put(id);
    h.put(fl);
    h.put(len);
    h.idle();
  endtask
  // header id, 0, length; then payload with the first byte at the top of pay
  task automatic reply(input ciq_row_t w);
    logic [8:0] e;
    frame(w.id, 8'h01, w.len);
    for (int k = 0; k < 200 && h.got.size() < w.len + 3; k++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    chk("reply count", 9'(w.len + 3), 9'(h.got.size()));
    for (int i = 0; i < w.len + 3; i++) begin
      e = i == 0 ? {1'b0, w.id} : i == 1 ? 9'h000 : i == 2 ? {1'b0, w.len} :
        {1'(i == w.len + 2), w.pay[127 - 8 * (i - 3) -: 8]};
      chk("reply byte", e, h.got[i]);
    end
    h.got.delete();
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (16) @(negedge mclk);
    chk("tx in reset", 9'h000, {tx_valid, tx_data});
    chk("flags in reset", 9'h002, {tx_last, 6'h00, rx_ready, bad_frame});
    rst_n = 1'b1;
    foreach (rows[r]) begin
      slow = r[0];
      reply(rows[r]);
    end
    // write flag, wrong length and unknown id, back to back
    slow = 1'b0;
    h.put(8'h40);
    h.put(8'h00);
    frame(8'h40, 8'h01, 8'h10);
    frame(8'h06, 8'h01, 8'h03);
    repeat (20) @(negedge mclk);
    chk("drops", 9'h003, 9'(n_bad));
    chk("no reply", 9'h000, 9'(h.got.size()));
    reply(rows[1]);
    // reset in mid reply abandons it; the port must come back ready and quiet
    frame(8'h01, 8'h01, 8'h10);
    repeat (4) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk("mid reset", 9'h002, {tx_last, tx_valid, 5'h00, rx_ready, bad_frame});
    h.got.delete();
    rst_n = 1'b1;
    reply(rows[4]);
    tally_and_finish();
  end
endmodule
